// [hw/crf_pkg.sv]
// Purpose: shared constants and types for the CAN receive filter path
// Assumes: one 20 MHz clock, frame fields delivered by a protocol engine
// Notes: segment length fields hold the quantum count minus one
package crf_pkg;
  localparam int ID_W = 29;
  localparam int DLC_W = 4;
  localparam int NBYTES = 8;
  localparam int NFILT = 6;
  localparam int NENT = 8;
  localparam int MASK0_ENT = 6;
  localparam int MASK1_ENT = 7;
  localparam int B0_FILTS = 2;
  localparam logic [ID_W-1:0] STD_ID_BITS = 29'h1FFC0000;
  localparam logic [1:0] HIT_B0_ROLL = 2'h3;
  localparam logic [1:0] HIT_B0_PLAIN = 2'h0;
  localparam logic [2:0] HIT_B1_DEFAULT = 3'h2;
  localparam logic [3:0] ICODE_RECEIVE_BUFFER_0 = 4'hC;
  localparam logic [3:0] ICODE_RECEIVE_BUFFER_1 = 4'hB;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_BIT_NS = 1000;
  localparam int MIN_BIT_CLKS = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] MIN_TQ = 5'h08;
  localparam logic [4:0] SEG_ENC_OFS = 5'h01;
  localparam logic [4:0] SYNC_TQ = 5'h01;

  typedef enum logic [1:0] {
    RXM_ALL = 2'b00,
    RXM_STD = 2'b01,
    RXM_EXT = 2'b10,
    RXM_ANY = 2'b11
  } crf_rxmode_t;

  typedef enum logic [1:0] {
    BT_SYNC = 2'b00,
    BT_SEG1 = 2'b01,
    BT_SEG2 = 2'b10
  } crf_bt_state_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic ide;
    logic rtr;
    logic [DLC_W-1:0] dlc;
  } crf_hdr_t;

  typedef struct packed {
    crf_hdr_t hdr;
    logic [NBYTES-1:0][7:0] data;
  } crf_frame_t;

  typedef struct packed {
    logic extended_id_select;
    logic [ID_W-1:0] id;
  } crf_filt_t;
endpackage

// [hw/crf_rx_filter_path.sv]
// Purpose: assembly buffer, acceptance filtering, two receive buffers, bit timing
// Assumes: inputs synchronous to clk; protocol engine gives header, bytes, end
// Notes: filter entries 0-5 are filters, 6 and 7 are masks 0 and 1
`timescale 1ns/1ps
module crf_rx_filter_path (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire logic cfg_mode,
  input wire logic rollover_enable,
  input wire crf_pkg::crf_rxmode_t receive_mode_sel0,
  input wire crf_pkg::crf_rxmode_t receive_mode_sel1,
  input wire logic [1:0] buffer_rx_int_enable,
  input wire logic error_int_enable,
  // mask and filter access
  input wire logic flt_wr,
  input wire logic [2:0] flt_wr_sel,
  input wire crf_pkg::crf_filt_t flt_wr_data,
  input wire logic [2:0] flt_rd_sel,
  output crf_pkg::crf_filt_t flt_rd_data_q,
  // frame input from protocol engine
  input wire logic rx_sof,
  input wire logic rx_hdr_valid,
  input wire crf_pkg::crf_hdr_t rx_hdr,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic rx_err,
  // receive buffers and status
  input wire logic [1:0] buffer_clear,
  input wire logic [1:0] overflow_clear,
  output crf_pkg::crf_frame_t receive_buffer_0_q,
  output crf_pkg::crf_frame_t receive_buffer_1_q,
  output logic [1:0] buffer_full_flag_q,
  output logic buffer0_overflow_q,
  output logic buffer1_overflow_q,
  output logic [3:0] buffer0_control_q,
  output logic [3:0] buffer1_control_q,
  output logic [3:0] module_status_icode_q,
  output logic rx_irq_q,
  output logic err_irq_q,
  // bit timing
  input wire logic [5:0] quantum_prescaler,
  input wire logic [2:0] prop_seg_sel,
  input wire logic [2:0] phase_segment_1,
  input wire logic [2:0] phase_segment_2,
  input wire logic [1:0] sjw_sel,
  input wire logic bus_idle,
  input wire logic can_rx,
  output logic tq_tick_q,
  output logic sample_q,
  output logic rx_bit_q,
  output logic tx_bit_start_q,
  output logic timing_cfg_bad_q
);
  crf_pkg::crf_filt_t filt_q [crf_pkg::NENT];
  crf_pkg::crf_frame_t asm_q;
  logic [3:0] byte_idx_q;
  logic frame_act_q;
  logic [crf_pkg::NFILT-1:0] match;
  logic [crf_pkg::ID_W-1:0] cmp_bits;
  logic done, acc0, acc1;
  logic load0, load1, ovf0, ovf1;
  logic f0;
  logic [2:0] f1, code1;
  logic [3:0] code0;

  // mask and filter storage, writable only while configuring
  genvar e;
  generate
    for (e = 0; e < crf_pkg::NENT; e++) begin : g_ent
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          filt_q[e] <= '0;
        end else if (flt_wr && cfg_mode && flt_wr_sel == 3'(e)) begin
          filt_q[e] <= flt_wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flt_rd_data_q <= '0;
    end else if (cfg_mode) begin
      flt_rd_data_q <= filt_q[flt_rd_sel];
    end else begin
      flt_rd_data_q <= '0;
    end
  end

  // assembly buffer: always takes the next frame, idle while configuring
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      asm_q <= '0;
      byte_idx_q <= '0;
      frame_act_q <= 1'b0;
    end else if (cfg_mode) begin
      frame_act_q <= 1'b0;
    end else begin
      if (rx_sof) begin
        frame_act_q <= 1'b1;
        byte_idx_q <= '0;
      end else if (rx_eof || rx_err) begin
        frame_act_q <= 1'b0;
      end
      if (frame_act_q && rx_hdr_valid) begin
        asm_q.hdr <= rx_hdr;
      end
      if (frame_act_q && rx_byte_valid && byte_idx_q < 4'(crf_pkg::NBYTES)) begin
        asm_q.data[byte_idx_q[2:0]] <= rx_byte;
        byte_idx_q <= byte_idx_q + 4'h1;
      end
    end
  end

  // acceptance: 11 bits for standard frames, all 29 for extended
  assign cmp_bits = asm_q.hdr.ide ? '1 : crf_pkg::STD_ID_BITS;

  genvar i;
  generate
    for (i = 0; i < crf_pkg::NFILT; i++) begin : g_match
      localparam int MI = (i < crf_pkg::B0_FILTS) ? crf_pkg::MASK0_ENT : crf_pkg::MASK1_ENT;
      crf_pkg::crf_rxmode_t mode;
      logic id_ok, type_ok;
      assign mode = (i < crf_pkg::B0_FILTS) ? receive_mode_sel0 : receive_mode_sel1;
      assign id_ok = ((asm_q.hdr.id ^ filt_q[i].id) & filt_q[MI].id & cmp_bits) == '0;
      always_comb begin
        case (mode)
          crf_pkg::RXM_STD: type_ok = !asm_q.hdr.ide && !filt_q[i].extended_id_select;
          crf_pkg::RXM_EXT: type_ok = asm_q.hdr.ide && filt_q[i].extended_id_select;
          default: type_ok = asm_q.hdr.ide == filt_q[i].extended_id_select;
        endcase
      end
      assign match[i] = id_ok && type_ok;
    end
  endgenerate

  // lowest numbered matching filter wins
  always_comb begin
    f0 = !match[0];
    f1 = crf_pkg::HIT_B1_DEFAULT;
    for (int k = crf_pkg::NFILT - 1; k >= crf_pkg::B0_FILTS; k--) begin
      if (match[k]) begin
        f1 = 3'(k);
      end
    end
  end

  // buffer selection, roll-over and overflow
  assign done = frame_act_q && !cfg_mode && (rx_eof || rx_err);
  always_comb begin
    load0 = 1'b0;
    load1 = 1'b0;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    code1 = f1;
    acc0 = (receive_mode_sel0 == crf_pkg::RXM_ANY) || (rx_eof && |match[1:0]);
    acc1 = (receive_mode_sel1 == crf_pkg::RXM_ANY) || (rx_eof && |match[5:2]);
    if (done) begin
      if (acc0) begin
        if (!buffer_full_flag_q[0]) begin
          load0 = 1'b1;
        end else if (rollover_enable) begin
          code1 = {2'b00, f0};
          if (!buffer_full_flag_q[1]) begin
            load1 = 1'b1;
          end else begin
            ovf1 = 1'b1;
          end
        end else begin
          ovf0 = 1'b1;
        end
      end else if (acc1) begin
        if (!buffer_full_flag_q[1]) begin
          load1 = 1'b1;
        end else begin
          ovf1 = 1'b1;
        end
      end
    end
    code0 = {asm_q.hdr.rtr, rollover_enable ? crf_pkg::HIT_B0_ROLL : crf_pkg::HIT_B0_PLAIN, f0};
  end

  // receive buffers take the whole assembly buffer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      receive_buffer_0_q <= '0;
      receive_buffer_1_q <= '0;
    end else begin
      if (load0) begin
        receive_buffer_0_q <= asm_q;
      end
      if (load1) begin
        receive_buffer_1_q <= asm_q;
      end
    end
  end

  // full and overflow flags: hardware set wins over software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer_full_flag_q <= '0;
      buffer0_overflow_q <= 1'b0;
      buffer1_overflow_q <= 1'b0;
    end else begin
      buffer_full_flag_q <= {load1, load0} | (buffer_full_flag_q & ~buffer_clear);
      buffer0_overflow_q <= ovf0 | (buffer0_overflow_q & ~overflow_clear[0]);
      buffer1_overflow_q <= ovf1 | (buffer1_overflow_q & ~overflow_clear[1]);
    end
  end

  // control nibbles, status code, interrupts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer0_control_q <= '0;
      buffer1_control_q <= '0;
      module_status_icode_q <= '0;
    end else if (load0) begin
      buffer0_control_q <= code0;
      module_status_icode_q <= crf_pkg::ICODE_RECEIVE_BUFFER_0;
    end else if (load1) begin
      buffer1_control_q <= {asm_q.hdr.rtr, code1};
      module_status_icode_q <= crf_pkg::ICODE_RECEIVE_BUFFER_1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= |({load1, load0} & buffer_rx_int_enable);
      err_irq_q <= (ovf0 || ovf1) && error_int_enable;
    end
  end

  // quantum prescaler: fixed divide by two, then by prescaler plus one
  logic [6:0] presc_q;
  logic tq;
  logic [4:0] seg_q, seg1_len, seg2_len, ntq, sjw_tq;
  logic [2:0] ext_q, short_q;
  logic sync_done_q, rx_prev_q, edge_fall;
  logic [11:0] clks_per_bit;
  crf_pkg::crf_bt_state_t bt_q;

  assign tq = presc_q == {quantum_prescaler, 1'b1};
  assign seg1_len = 5'(prop_seg_sel) + 5'(phase_segment_1) + crf_pkg::SEG_ENC_OFS
                    + crf_pkg::SEG_ENC_OFS + 5'(ext_q);
  assign seg2_len = 5'(phase_segment_2) + crf_pkg::SEG_ENC_OFS - 5'(short_q);
  assign ntq = crf_pkg::SYNC_TQ + 5'(prop_seg_sel) + 5'(phase_segment_1)
               + 5'(phase_segment_2) + 5'(3 * crf_pkg::SEG_ENC_OFS);
  assign sjw_tq = 5'(sjw_sel) + crf_pkg::SEG_ENC_OFS;
  assign edge_fall = rx_prev_q && !can_rx;
  assign clks_per_bit = (12'({quantum_prescaler, 1'b1}) + 12'h001) * 12'(ntq);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timing_cfg_bad_q <= 1'b0;
      rx_prev_q <= 1'b1;
    end else begin
      timing_cfg_bad_q <= (ntq < crf_pkg::MIN_TQ) ||
                          (clks_per_bit < 12'(crf_pkg::MIN_BIT_CLKS));
      rx_prev_q <= can_rx;
    end
  end

  // bit timing loop: hard sync when idle, bounded resync inside a frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= '0;
      bt_q <= crf_pkg::BT_SYNC;
      seg_q <= '0;
      ext_q <= '0;
      short_q <= '0;
      sync_done_q <= 1'b0;
      tq_tick_q <= 1'b0;
      sample_q <= 1'b0;
      rx_bit_q <= 1'b1;
      tx_bit_start_q <= 1'b0;
    end else if (cfg_mode) begin
      presc_q <= '0;
      bt_q <= crf_pkg::BT_SYNC;
      seg_q <= '0;
      tq_tick_q <= 1'b0;
      sample_q <= 1'b0;
      tx_bit_start_q <= 1'b0;
    end else begin
      presc_q <= tq ? '0 : presc_q + 7'h01;
      tq_tick_q <= tq;
      sample_q <= 1'b0;
      tx_bit_start_q <= 1'b0;
      if (tq) begin
        case (bt_q)
          crf_pkg::BT_SYNC: begin
            bt_q <= crf_pkg::BT_SEG1;
            seg_q <= '0;
          end
          crf_pkg::BT_SEG1: begin
            if (seg_q + 5'h01 >= seg1_len) begin
              bt_q <= crf_pkg::BT_SEG2;
              seg_q <= '0;
              sample_q <= 1'b1;
              rx_bit_q <= can_rx;
            end else begin
              seg_q <= seg_q + 5'h01;
            end
          end
          default: begin
            if (seg_q + 5'h01 >= seg2_len) begin
              bt_q <= crf_pkg::BT_SYNC;
              seg_q <= '0;
              ext_q <= '0;
              short_q <= '0;
              sync_done_q <= 1'b0;
              tx_bit_start_q <= 1'b1;
            end else begin
              seg_q <= seg_q + 5'h01;
            end
          end
        endcase
      end
      if (edge_fall && bus_idle) begin
        presc_q <= '0;
        bt_q <= crf_pkg::BT_SYNC;
        seg_q <= '0;
        ext_q <= '0;
        short_q <= '0;
        sync_done_q <= 1'b1;
      end else if (edge_fall && !sync_done_q && rx_bit_q) begin
        sync_done_q <= 1'b1;
        if (bt_q == crf_pkg::BT_SEG1) begin
          ext_q <= (seg_q + 5'h01 <= sjw_tq) ? 3'(seg_q + 5'h01) : 3'(sjw_tq);
        end else if (bt_q == crf_pkg::BT_SEG2) begin
          if (seg2_len - seg_q <= sjw_tq) begin
            presc_q <= '0;
            bt_q <= crf_pkg::BT_SYNC;
            seg_q <= '0;
            ext_q <= '0;
            short_q <= '0;
          end else begin
            short_q <= 3'(sjw_tq);
          end
        end
      end
    end
  end
endmodule

// [tb/crf_can_node.sv]
// Purpose: far-side node model that feeds frame fields to the filter path
// Assumes: runs on the bench clock, drives just after rising edges
// Notes: fields without their strobe are held through byte gaps, scrambled otherwise
`timescale 1ns/1ps
module crf_can_node (
  // clock
  input logic clk,
  // frame fields
  output logic rx_sof = 1'b0,
  output logic rx_hdr_valid = 1'b0,
  output crf_pkg::crf_hdr_t rx_hdr = '0,
  output logic rx_byte_valid = 1'b0,
  output logic [7:0] rx_byte = 8'h00,
  output logic rx_eof = 1'b0,
  output logic rx_err = 1'b0,
  // bus level
  output logic bus_idle = 1'b1,
  output logic can_rx = 1'b1
);
  task automatic send(input crf_pkg::crf_hdr_t h, input logic [63:0] d, input int nb,
                      input logic err, input int slow);
    @(posedge clk);
    rx_sof <= 1'b1;
    bus_idle <= 1'b0;
    can_rx <= 1'b0;
    @(posedge clk);
    rx_sof <= 1'b0;
    rx_hdr_valid <= 1'b1;
    rx_hdr <= h;
    for (int i = 0; i < nb; i++) begin
      repeat (slow) begin
        @(posedge clk);
        rx_hdr_valid <= 1'b0;
        rx_byte_valid <= 1'b0;
      end
      @(posedge clk);
      rx_hdr_valid <= 1'b0;
      rx_hdr <= ~h;
      rx_byte_valid <= 1'b1;
      rx_byte <= d[8*i +: 8];
      can_rx <= d[8*i];
    end
    @(posedge clk);
    rx_hdr_valid <= 1'b0;
    rx_hdr <= ~h;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_eof <= ~err;
    rx_err <= err;
    @(posedge clk);
    rx_eof <= 1'b0;
    rx_err <= 1'b0;
    bus_idle <= 1'b1;
    can_rx <= 1'b1;
  endtask
endmodule

// [tb/crf_rx_filter_path_monitor.sv]
// Purpose: port-level checks of the receive filter path
// Assumes: one clock domain, rstn active low
// Notes: bound onto every instance of the top module
`timescale 1ns/1ps
module crf_rx_filter_path_monitor (
  // clock and reset
  input logic clk,
  input logic rstn,
  // controls
  input logic cfg_mode,
  input logic [1:0] buffer_rx_int_enable,
  input logic error_int_enable,
  input logic [1:0] buffer_clear,
  input logic [2:0] prop_seg_sel,
  input logic [2:0] phase_segment_1,
  input logic [2:0] phase_segment_2,
  // observed state
  input crf_pkg::crf_filt_t flt_rd_data_q,
  input crf_pkg::crf_frame_t receive_buffer_0_q,
  input logic [1:0] buffer_full_flag_q,
  input logic buffer0_overflow_q,
  input logic buffer1_overflow_q,
  input logic [3:0] module_status_icode_q,
  input logic rx_irq_q,
  input logic err_irq_q,
  input logic timing_cfg_bad_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_zero; !cfg_mode |=> flt_rd_data_q == '0; endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("filter read not zero outside configuration");
  property p_rx_irq;
    rx_irq_q == ((buffer_full_flag_q & ~$past(buffer_full_flag_q)
                  & $past(buffer_rx_int_enable)) != 2'h0);
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive interrupt does not match enabled load");
  property p_err_irq;
    err_irq_q |-> $past(error_int_enable) && (buffer0_overflow_q || buffer1_overflow_q);
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error interrupt without enabled overflow");
  property p_full_held;
    buffer_full_flag_q[0] && !buffer_clear[0] |=> buffer_full_flag_q[0];
  endproperty
  a_full_held: assert property (p_full_held)
    else $error("full flag dropped without clear");
  property p_no_reload;
    buffer_full_flag_q[0] && !buffer_clear[0] |=> $stable(receive_buffer_0_q);
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("full buffer 0 overwritten");
  property p_icode0;
    $rose(buffer_full_flag_q[0]) |-> module_status_icode_q == crf_pkg::ICODE_RECEIVE_BUFFER_0;
  endproperty
  a_icode0: assert property (p_icode0)
    else $error("status code wrong after buffer 0 load");
  property p_icode1;
    $rose(buffer_full_flag_q[1]) |-> module_status_icode_q == crf_pkg::ICODE_RECEIVE_BUFFER_1;
  endproperty
  a_icode1: assert property (p_icode1)
    else $error("status code wrong after buffer 1 load");
  property p_cfg_quiet;
    cfg_mode |=> (buffer_full_flag_q & ~$past(buffer_full_flag_q)) == 2'h0;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("frame loaded in configuration mode");
  property p_short_bit;
    ({2'h0, prop_seg_sel} + phase_segment_1 + phase_segment_2 + 5'h04 < 5'h08) [*3]
      |-> timing_cfg_bad_q;
  endproperty
  a_short_bit: assert property (p_short_bit)
    else $error("bit under eight quanta not flagged");
endmodule
bind crf_rx_filter_path crf_rx_filter_path_monitor crf_rx_filter_path_monitor_i (.*);

// [tb/crf_rx_filter_path_bench.sv]
// Purpose: self-checking bench for the receive filter path
// Assumes: 20 MHz clock, node model drives the frame fields
// Notes: driver queues expected loads, a watcher pops them
`timescale 1ns/1ps
module crf_rx_filter_path_bench;
  typedef struct packed {
    logic [1:0] b;
    logic [3:0] c;
    crf_pkg::crf_frame_t f;
  } crf_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cfg_mode = 1'b1;
  logic rollover_enable = 1'b0;
  crf_pkg::crf_rxmode_t receive_mode_sel0 = crf_pkg::RXM_ALL;
  crf_pkg::crf_rxmode_t receive_mode_sel1 = crf_pkg::RXM_ALL;
  logic [1:0] buffer_rx_int_enable = 2'h3;
  logic error_int_enable = 1'b1;
  logic flt_wr = 1'b0;
  logic [2:0] flt_wr_sel = 3'h0;
  crf_pkg::crf_filt_t flt_wr_data = '0;
  logic [2:0] flt_rd_sel = 3'h0;
  logic [1:0] buffer_clear = 2'h0;
  logic [1:0] overflow_clear = 2'h0;
  logic [5:0] quantum_prescaler = 6'h01;
  logic [2:0] prop_seg_sel = 3'h2;
  logic [2:0] phase_segment_1 = 3'h1;
  logic [2:0] phase_segment_2 = 3'h1;
  logic [1:0] sjw_sel = 2'h0;
  crf_pkg::crf_filt_t flt_rd_data_q;
  crf_pkg::crf_frame_t receive_buffer_0_q, receive_buffer_1_q, assembly_buffer = '0;
  crf_pkg::crf_hdr_t rx_hdr;
  logic [1:0] buffer_full_flag_q, xf = 2'h0, pf = 2'h0;
  logic [3:0] buffer0_control_q, buffer1_control_q, module_status_icode_q;
  logic [7:0] rx_byte;
  logic buffer0_overflow_q, buffer1_overflow_q, rx_irq_q, err_irq_q, tq_tick_q, sample_q;
  logic rx_bit_q, tx_bit_start_q, timing_cfg_bad_q, rx_sof, rx_hdr_valid, rx_byte_valid;
  logic rx_eof, rx_err, bus_idle, can_rx;
  logic [31:0] seed = 32'h464F;
  crf_pkg::crf_filt_t ent [8];
  crf_note_t q[$];
  int n_fail = 0;
  int tests_run = 0;
  int k;
  always #25 clk = ~clk;
  crf_rx_filter_path crf_rx_filter_path_i (.*);
  crf_can_node crf_can_node_i (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  function automatic int hit(crf_pkg::crf_hdr_t h, int lo, int hi, crf_pkg::crf_rxmode_t m);
    logic [28:0] msk;
    msk = ent[lo == 0 ? 6 : 7].id & (h.ide ? 29'h1FFFFFFF : crf_pkg::STD_ID_BITS);
    for (int f = lo; f <= hi; f++) begin
      if (ent[f].extended_id_select == h.ide && !(m == crf_pkg::RXM_STD && h.ide) &&
          !(m == crf_pkg::RXM_EXT && !h.ide) && ((h.id ^ ent[f].id) & msk) == 29'h0)
        return f;
    end
    return (m == crf_pkg::RXM_ANY) ? 8 : -1;
  endfunction
  task automatic wr(input int s, input crf_pkg::crf_filt_t v);
    @(posedge clk);
    flt_wr <= 1'b1;
    flt_wr_sel <= 3'(s);
    flt_wr_data <= v;
    @(posedge clk);
    flt_wr <= 1'b0;
  endtask
  task automatic clr();
    @(posedge clk);
    buffer_clear <= 2'h3;
    overflow_clear <= 2'h3;
    @(posedge clk);
    buffer_clear <= 2'h0;
    overflow_clear <= 2'h0;
    xf = 2'h0;
  endtask
  task automatic tick_gap(input int s, output int c);
    logic [2:0] v;
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
      v = {tx_bit_start_q, sample_q, tq_tick_q};
    end while (v[s] !== 1'b1 && c < 200);
    if (c >= 200) begin
      chk(1'b0, "no quantum tick");
      report_and_stop();
    end
  endtask
  task automatic frame(input logic [28:0] id, input logic ide, input logic rtr, input int nb,
                       input logic err);
    crf_pkg::crf_hdr_t h;
    logic [63:0] d;
    int a, b;
    crf_note_t n;
    @(posedge clk);
    h = '{id: id, ide: ide, rtr: rtr, dlc: 4'(nb)};
    d = {rnd(), rnd()};
    for (int i = 0; i < nb; i++) assembly_buffer.data[i] = d[8*i +: 8];
    assembly_buffer.hdr = h;
    a = hit(h, 0, 1, receive_mode_sel0);
    b = hit(h, 2, 5, receive_mode_sel1);
    if (err && receive_mode_sel0 != crf_pkg::RXM_ANY) a = -1;
    if (err && receive_mode_sel1 != crf_pkg::RXM_ANY) b = -1;
    n.f = assembly_buffer;
    n.b = 2'h0;
    n.c = {rtr, rollover_enable, rollover_enable, a[0]};
    if (a >= 0 && xf[0]) begin
      n.b = rollover_enable ? (xf[1] ? 2'h3 : 2'h1) : 2'h2;
      n.c = {rtr, 2'h0, a[0]};
    end else if (a < 0) begin
      n.b = xf[1] ? 2'h3 : 2'h1;
      n.c = {rtr, (b == 8) ? crf_pkg::HIT_B1_DEFAULT : 3'(b)};
    end
    if (a >= 0 || b >= 0) q.push_back(n);
    if ((a >= 0 || b >= 0) && n.b < 2'h2) xf[n.b] = 1'b1;
    crf_can_node_i.send(h, d, nb, err, int'(rnd() % 3));
  endtask
  always @(posedge clk) begin
    crf_note_t g, e;
    #1;
    if (rstn && ((buffer_full_flag_q & ~pf) != 2'h0 || err_irq_q === 1'b1)) begin
      g.b = err_irq_q ? {1'b1, buffer1_overflow_q} : {1'b0, buffer_full_flag_q[1] & ~pf[1]};
      g.f = g.b[0] ? receive_buffer_1_q : receive_buffer_0_q;
      g.c = g.b[0] ? buffer1_control_q : buffer0_control_q;
      if (q.size() == 0) begin
        chk(1'b0, "result with nothing expected");
      end else begin
        e = q.pop_front();
        if (e.b < 2'h2) chk(g === e && module_status_icode_q === (e.b[0] ?
            crf_pkg::ICODE_RECEIVE_BUFFER_1 : crf_pkg::ICODE_RECEIVE_BUFFER_0), "load mismatch");
        else chk(g.b === e.b && (e.b[0] || buffer0_overflow_q === 1'b1),
            "overflow mismatch");
      end
    end
    pf = buffer_full_flag_q;
  end
  initial begin
    ent = '{'{1'b0, 29'h048C0000}, '{1'b1, 29'h0ABCDEF0}, '{1'b1, 29'h01234567},
            '{1'b0, 29'h15540000}, '{1'b0, 29'h15540000}, '{1'b1, 29'h00000055},
            '{1'b0, crf_pkg::STD_ID_BITS}, '{1'b0, 29'h1FFFFFFF}};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int s = 0; s < 8; s++) wr(s, ent[s]);
    flt_rd_sel <= 3'h5;
    repeat (2) @(posedge clk);
    #1 chk(flt_rd_data_q === ent[5], "filter readback");
    crf_can_node_i.send('{29'h048C0000, 1'b0, 1'b0, 4'h0}, 64'h0, 0, 1'b0, 0);
    @(posedge clk);
    cfg_mode <= 1'b0;
    wr(0, '1);
    for (int p = 0; p < 64; p += 21) begin
      @(posedge clk);
      quantum_prescaler <= 6'(p);
      tick_gap(0, k);
      tick_gap(0, k);
      chk(k == 2 * (p + 1) && timing_cfg_bad_q === (p == 0), "quantum period");
    end
    @(posedge clk);
    quantum_prescaler <= 6'h01;
    {prop_seg_sel, phase_segment_1, phase_segment_2} <= 9'h000;
    repeat (5) @(posedge clk);
    #1 chk(timing_cfg_bad_q === 1'b1, "short bit not flagged");
    @(posedge clk);
    prop_seg_sel <= 3'h2;
    {phase_segment_1, phase_segment_2} <= 6'h09;
    tick_gap(2, k);
    tick_gap(1, k);
    chk(k == 24 && rx_bit_q === 1'b1, "sample point");
    tick_gap(2, k);
    chk(k == 8, "bit end");
    frame(29'h048C0000, 1'b0, 1'b0, 8, 1'b0);
    frame(29'h1FFC0000, 1'b0, 1'b0, 8, 1'b0);
    frame(29'h15540000, 1'b0, 1'b0, 2, 1'b0);
    frame(29'h048C0000, 1'b0, 1'b0, 1, 1'b0);
    clr();
    rollover_enable <= 1'b1;
    frame(29'h048C0000, 1'b0, 1'b1, 0, 1'b0);
    frame(ent[1].id ^ (rnd() & ~crf_pkg::STD_ID_BITS), 1'b1, 1'b0, 5, 1'b0);
    frame(29'h048C0000, 1'b0, 1'b0, 3, 1'b0);
    clr();
    rollover_enable <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      receive_mode_sel1 <= crf_pkg::crf_rxmode_t'(m);
      frame(29'h15540000, 1'b0, 1'b0, 4, 1'b0);
      frame(29'h01234567, 1'b1, 1'b0, 4, 1'b0);
      clr();
    end
    frame(29'h1FFC0000, 1'b0, 1'b0, 3, 1'b1);
    clr();
    receive_mode_sel1 <= crf_pkg::RXM_ALL;
    buffer_rx_int_enable <= 2'h1;
    for (int i = 0; i < 8; i++) begin
      k = int'(rnd() % 6);
      frame(ent[k].id ^ (29'h1 << (rnd() % 29)), ent[k].extended_id_select, 1'b0, 8, 1'b0);
      clr();
    end
    repeat (4) @(posedge clk);
    chk(q.size() == 0, "missing result");
    report_and_stop();
  end
endmodule
